// file: rtl/smte_spi_master.v
// spi master transfer engine with register port, status and interrupt
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
`include "smte_defines.vh"
module smte_spi_master #(
  parameter DW = 8, // bits per transfer
  parameter NCS = 4 // number of chip selects
) (
  // clock and reset
  input wire i_clk,
  input wire i_reset_n,
  // register port
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  // serial link
  output reg o_serial_clock_out,
  output reg o_mosi,
  input wire i_miso,
  output reg [NCS-1:0] o_cs_n,
  // dma request and interrupt
  output reg o_dma_tx_req,
  output reg o_irq
);

  // decoded register accesses
  wire wr_ctrl = i_wr && (i_addr == `SMTE_ADDR_CTRL);
  wire wr_mode = i_wr && (i_addr == `SMTE_ADDR_MODE);
  wire wr_tx = i_wr && (i_addr == `SMTE_ADDR_TX);
  wire wr_mask = i_wr && (i_addr == `SMTE_ADDR_IMASK);
  wire wr_pend = i_wr && (i_addr == `SMTE_ADDR_IPEND);
  wire rd_rx = i_rd && (i_addr == `SMTE_ADDR_RX);
  wire rd_stat = i_rd && (i_addr == `SMTE_ADDR_STATUS);

  // software state
  reg enable; // interface enable
  reg [31:0] serial_mode_reg; // wait bit, select, divider, delay
  reg [DW-1:0] tx_holding_reg; // word waiting to go out
  reg [DW-1:0] rx_holding_reg; // last received word
  reg [DW-1:0] shift_reg; // shared shift register
  reg tx_holding_empty_flag; // tx holding free
  reg tx_all_done_flag; // nothing left to send
  reg rx_holding_full_flag; // unread rx word
  reg rx_overrun_flag; // rx word lost
  reg [3:0] int_mask; // interrupt enables
  reg [3:0] int_pend; // sticky event bits

  // engine state
  reg [1:0] state;
  reg [7:0] div_cnt; // baud divider count
  reg [7:0] dly_cnt; // delay after last transfer
  reg [4:0] bit_cnt; // bits left to shift
  reg phase; // 0: low half, 1: high half

  // mode register fields
  wire wait_rx_read_before_tx = serial_mode_reg[`SMTE_MODE_WAIT];
  wire [1:0] peripheral_select_field =
    serial_mode_reg[`SMTE_MODE_PS_HI:`SMTE_MODE_PS_LO];
  wire [7:0] baud_div = serial_mode_reg[`SMTE_MODE_DIV_HI:`SMTE_MODE_DIV_LO];
  wire [7:0] inter_transfer_delay =
    serial_mode_reg[`SMTE_MODE_DLY_HI:`SMTE_MODE_DLY_LO];

  // one-cycle enable pulse at each half serial clock period
  // reloaded in idle, so the first half period has full length
  wire baud_tick = (div_cnt == 8'h00);

  // a queued word may start when rx side permits
  wire rx_ok = !wait_rx_read_before_tx || !rx_holding_full_flag ||
    rd_rx;
  wire have_word = !tx_holding_empty_flag;
  // last falling edge of the word
  wire word_end = (state == `SMTE_S_SHIFT) && baud_tick && phase &&
    (bit_cnt == 5'h01);
  // load a new word: from idle, during the delay or straight after a finished word
  wire load_now = enable && have_word && rx_ok &&
    ((state == `SMTE_S_IDLE) || (state == `SMTE_S_DELAY) ||
    word_end);

  // chip select decode, one line per slave
  function [NCS-1:0] cs_decode;
    input [1:0] sel;
    begin
      cs_decode = ~({{(NCS-1){1'b0}}, 1'b1} << sel);
    end
  endfunction

  // baud divider, restarted when a word loads
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      div_cnt <= 8'h00;
    end else if (load_now || baud_tick || state == `SMTE_S_IDLE) begin
      div_cnt <= baud_div;
    end else begin
      div_cnt <= div_cnt - 8'h01;
    end
  end

  // transfer engine: shift, sample, chip select, delay
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state <= `SMTE_S_IDLE;
      shift_reg <= {DW{1'b0}};
      bit_cnt <= 5'h00;
      phase <= 1'b0;
      dly_cnt <= 8'h00;
      o_serial_clock_out <= 1'b0;
      o_mosi <= 1'b0;
      o_cs_n <= {NCS{1'b1}};
    end else if (!enable) begin
      // disabling aborts and releases the bus
      state <= `SMTE_S_IDLE;
      o_serial_clock_out <= 1'b0;
      o_cs_n <= {NCS{1'b1}};
    end else if (load_now) begin
      // tx holding moves into the shift register
      state <= `SMTE_S_SHIFT;
      shift_reg <= tx_holding_reg;
      o_mosi <= tx_holding_reg[DW-1];
      bit_cnt <= DW[4:0];
      phase <= 1'b0;
      o_serial_clock_out <= 1'b0;
      // a word end with a word waiting loads here too, cs stays low
      o_cs_n <= cs_decode(peripheral_select_field);
    end else begin
      case (state)
        `SMTE_S_SHIFT: begin
          if (baud_tick) begin
            phase <= ~phase;
            o_serial_clock_out <= ~phase;
            if (!phase) begin
              // rising edge: sample miso
              shift_reg <= {shift_reg[DW-2:0], i_miso};
            end else begin
              // falling edge: next bit or end of word
              o_mosi <= shift_reg[DW-1];
              bit_cnt <= bit_cnt - 5'h01;
              if (bit_cnt == 5'h01) begin
                state <= `SMTE_S_DELAY;
                dly_cnt <= inter_transfer_delay;
              end
            end
          end
        end
        `SMTE_S_DELAY: begin
          // cs held through delay after the last word
          if (dly_cnt == 8'h00) begin
            state <= `SMTE_S_IDLE;
            o_cs_n <= {NCS{1'b1}};
          end else begin
            dly_cnt <= dly_cnt - 8'h01;
          end
        end
        `SMTE_S_IDLE: begin
          o_cs_n <= {NCS{1'b1}};
        end
        default: begin
          state <= `SMTE_S_IDLE;
        end
      endcase
    end
  end

  // received word completes at the word end
  // the last sample was taken a half period earlier
  wire rx_done = word_end && enable;
  wire [DW-1:0] rx_word = shift_reg;

  // holding registers and status flags
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      enable <= 1'b0;
      serial_mode_reg <= `SMTE_MODE_RST;
      tx_holding_reg <= {DW{1'b0}};
      rx_holding_reg <= {DW{1'b0}};
      tx_holding_empty_flag <= 1'b0;
      tx_all_done_flag <= 1'b0;
      rx_holding_full_flag <= 1'b0;
      rx_overrun_flag <= 1'b0;
    end else begin
      if (wr_mode) begin
        serial_mode_reg <= i_wdata;
      end
      if (wr_ctrl) begin
        enable <= i_wdata[`SMTE_CTRL_EN];
        if (i_wdata[`SMTE_CTRL_EN] && !enable) begin
          // becoming enabled shows both flags set
          tx_holding_empty_flag <= 1'b1;
          tx_all_done_flag <= 1'b1;
        end
      end
      // tx holding: write clears empty, load sets it
      // a write while disabled is dropped, nothing queues
      if (wr_tx && enable) begin
        tx_holding_reg <= i_wdata[DW-1:0];
        tx_holding_empty_flag <= 1'b0;
        tx_all_done_flag <= 1'b0;
      end else if (load_now) begin
        tx_holding_empty_flag <= 1'b1;
      end
      // done only after last word and its delay
      if (enable && state == `SMTE_S_DELAY && dly_cnt == 8'h00 &&
          !load_now && !wr_tx) begin
        tx_all_done_flag <= 1'b1;
      end
      // rx holding: new word wins over a read clear
      if (rx_done) begin
        rx_holding_reg <= rx_word;
        rx_holding_full_flag <= 1'b1;
      end else if (rd_rx) begin
        rx_holding_full_flag <= 1'b0;
      end
      // overrun: set wins over status-read clear
      if (rx_done && rx_holding_full_flag && !rd_rx) begin
        rx_overrun_flag <= 1'b1;
      end else if (rd_stat) begin
        rx_overrun_flag <= 1'b0;
      end
    end
  end

  // event pulses for the interrupt status
  // each is one cycle long; the pending bits hold them
  wire [3:0] events;
  assign events[`SMTE_ST_TDE] = load_now;
  assign events[`SMTE_ST_TXD] = enable && state == `SMTE_S_DELAY &&
    dly_cnt == 8'h00 && !load_now;
  assign events[`SMTE_ST_RXF] = rx_done;
  assign events[`SMTE_ST_OVR] = rx_done && rx_holding_full_flag && !rd_rx;

  // interrupt mask and sticky pending, write one to clear
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      int_mask <= 4'h0;
      int_pend <= 4'h0;
      o_irq <= 1'b0;
    end else begin
      if (wr_mask) begin
        int_mask <= i_wdata[3:0];
      end
      // set beats clear in the same cycle
      int_pend <= (int_pend & ~(wr_pend ? i_wdata[3:0] : 4'h0)) | events;
      // one cycle behind pending so the pin comes from a flop
      o_irq <= |(int_pend & int_mask);
    end
  end

  // dma request follows the tx empty flag
  // dropped in the write cycle itself so a burst cannot overrun
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_dma_tx_req <= 1'b0;
    end else begin
      o_dma_tx_req <= enable && tx_holding_empty_flag && !wr_tx;
    end
  end

  // read data, valid the cycle after the read strobe
  // idle cycles and unmapped addresses return zero
  always @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      case (i_addr)
        `SMTE_ADDR_CTRL: o_rdata <= {31'h0, enable};
        `SMTE_ADDR_MODE: o_rdata <= serial_mode_reg;
        `SMTE_ADDR_TX: o_rdata <= {{(32-DW){1'b0}}, tx_holding_reg};
        `SMTE_ADDR_RX: o_rdata <= {{(32-DW){1'b0}}, rx_holding_reg};
        `SMTE_ADDR_STATUS: o_rdata <= {26'h0, state != `SMTE_S_IDLE, enable,
          rx_overrun_flag, rx_holding_full_flag, tx_all_done_flag,
          tx_holding_empty_flag};
        `SMTE_ADDR_IMASK: o_rdata <= {28'h0, int_mask};
        `SMTE_ADDR_IPEND: o_rdata <= {28'h0, int_pend};
        default: o_rdata <= 32'h0000_0000;
      endcase
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end

endmodule

// file: rtl/smte_defines.vh
// register offsets, field positions, reset values and states for the engine
`ifndef SMTE_DEFINES_VH
`define SMTE_DEFINES_VH
// register word addresses
`define SMTE_ADDR_CTRL 4'h0
`define SMTE_ADDR_MODE 4'h1
`define SMTE_ADDR_TX 4'h2
`define SMTE_ADDR_RX 4'h3
`define SMTE_ADDR_STATUS 4'h4
`define SMTE_ADDR_IMASK 4'h5
`define SMTE_ADDR_IPEND 4'h6
// control register fields
`define SMTE_CTRL_EN 0
`define SMTE_CTRL_LAST 1
// mode register fields
`define SMTE_MODE_WAIT 0
`define SMTE_MODE_PS_LO 4
`define SMTE_MODE_PS_HI 5
`define SMTE_MODE_DIV_LO 8
`define SMTE_MODE_DIV_HI 15
`define SMTE_MODE_DLY_LO 16
`define SMTE_MODE_DLY_HI 23
// status and interrupt bit positions
`define SMTE_ST_TDE 0
`define SMTE_ST_TXD 1
`define SMTE_ST_RXF 2
`define SMTE_ST_OVR 3
`define SMTE_ST_EN 4
`define SMTE_ST_BUSY 5
// reset values
`define SMTE_MODE_RST 32'h0000_0100
`define SMTE_DUMMY_WORD 8'hff
// engine states
`define SMTE_S_IDLE 2'h0
`define SMTE_S_SHIFT 2'h1
`define SMTE_S_DELAY 2'h2
`endif

// file: testbench/smte_spi_master_checker.sv
// port checker for the spi master engine
`timescale 1ns/1ns
`include "smte_defines.vh"
module smte_spi_master_checker #(parameter DW = 8, parameter NCS = 4) (
  // clock, reset and register port
  input wire i_clk,
  input wire i_reset_n,
  input wire [3:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [31:0] o_rdata,
  // serial link, dma and interrupt
  input wire o_serial_clock_out,
  input wire o_mosi,
  input wire i_miso,
  input wire [NCS-1:0] o_cs_n,
  input wire o_dma_tx_req,
  input wire o_irq
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_reset_n);
  // read data only in the answer cycle
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 0)
    else $error("read data outside answer");
  a_rx_upper: assert property (
    $past(i_rd && i_addr == `SMTE_ADDR_RX) |-> (o_rdata >> DW) == 0)
    else $error("rx upper bits set");
  a_one_select: assert property ($onehot0(~o_cs_n))
    else $error("several selects low");
  a_clock_in_frame: assert property (
    o_serial_clock_out |-> !(&o_cs_n)) else $error("clock outside frame");
  a_mosi_steady: assert property (
    o_serial_clock_out && $past(o_serial_clock_out) |-> $stable(o_mosi))
    else $error("mosi moved while clock high");
  a_cs_steady: assert property (
    o_serial_clock_out |-> $stable(o_cs_n)) else $error("select moved");
  a_cs_clock_low: assert property (
    $changed(o_cs_n) |-> !o_serial_clock_out) else $error("select edge");
  a_dma_fall_write: assert property (
    $fell(o_dma_tx_req) |-> $past(i_wr) || $past(i_wr, 2) || $past(i_wr, 3))
    else $error("dma request fell without a write");
  // main scenarios reached
  c_frame: cover property ($fell(&o_cs_n));
  c_irq: cover property ($rose(o_irq));
  c_dma: cover property ($fell(o_dma_tx_req));
endmodule
bind smte_spi_master smte_spi_master_checker #(.DW(DW), .NCS(NCS)) i_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_serial_clock_out(o_serial_clock_out), .o_mosi(o_mosi), .i_miso(i_miso),
  .o_cs_n(o_cs_n), .o_dma_tx_req(o_dma_tx_req), .o_irq(o_irq));

// file: testbench/smte_slave_model.sv
// behavioural serial slave facing the engine
`timescale 1ns/1ns
module smte_slave_model (
  // clock for the idle pattern
  input wire i_clk,
  // serial link and words
  input wire i_sclk,
  input wire i_cs_n,
  input wire i_mosi,
  output wire o_miso,
  input wire [7:0] i_reply,
  output logic [7:0] o_got
);
  logic [7:0] tx_sh = 8'h00; // outgoing bits
  logic [7:0] rx_sh = 8'h00; // incoming bits
  logic [3:0] cnt = 4'h0; // bits taken
  logic idle_bit = 1'b0; // toggles so a released line never holds
  always @(posedge i_clk) idle_bit <= ~idle_bit;
  assign o_miso = i_cs_n ? idle_bit : tx_sh[7];
  // reply word ready at select
  always @(negedge i_cs_n) begin
    tx_sh = i_reply;
    cnt = 4'h0;
  end
  // take master data on the rising clock
  always @(posedge i_sclk) if (!i_cs_n) begin
    rx_sh = {rx_sh[6:0], i_mosi};
    cnt = cnt + 4'h1;
  end
  // shift on the falling clock, reload after a whole word
  always @(negedge i_sclk) if (!i_cs_n) begin
    if (cnt == 4'h8) begin
      o_got = rx_sh;
      tx_sh = i_reply;
      cnt = 4'h0;
    end else begin
      tx_sh = {tx_sh[6:0], 1'b0};
    end
  end
endmodule

// file: testbench/spi_master_transfer_engine_tb.sv
// self-checking bench for the spi master engine
`timescale 1ns/1ns
`include "smte_defines.vh"
module spi_master_transfer_engine_tb;
  logic clk = 1'b0; // system clock
  logic rst_n = 1'b0; // reset, active low
  logic [3:0] addr = 4'h0; // register port
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] reply = 8'h00; // slave answer word
  logic [3:0] seen_cs = 4'hf; // last active select pattern
  logic [31:0] d; // last read data
  wire [31:0] rdata;
  wire sclk, mosi, miso, dma, irq;
  wire [3:0] cs_n;
  wire [7:0] got;
  int num_errors = 0;
  int tests_run = 0;
  int pulses = 0; // serial clock rises seen
  // select, transmit word, slave reply
  logic [19:0] rows [4] = '{20'h0a53c, 20'h1ffc3, 20'h20180, 20'h37eff};
  smte_spi_master #(.DW(8), .NCS(4)) i_dut (.i_clk(clk), .i_reset_n(rst_n),
    .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
    .o_serial_clock_out(sclk), .o_mosi(mosi), .i_miso(miso), .o_cs_n(cs_n),
    .o_dma_tx_req(dma), .o_irq(irq));
  smte_slave_model i_slave (.i_clk(clk), .i_sclk(sclk), .i_cs_n(&cs_n),
    .i_mosi(mosi), .o_miso(miso), .i_reply(reply), .o_got(got));
  initial forever #5 clk = ~clk;
  always @(posedge clk) if (!(&cs_n)) seen_cs <= cs_n;
  always @(posedge sclk) pulses++;
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // bounded wait for the select lines to go idle
  task automatic wait_done();
    int k;
    repeat (3) @(posedge clk);
    for (k = 0; k < 900 && !(&cs_n); k++) @(posedge clk);
    if (k == 900) begin
      num_errors++;
      results();
    end else begin
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    reg_wr(`SMTE_ADDR_CTRL, 32'h1);
    for (int r = 0; r < 4; r++) begin
      reply = rows[r][7:0];
      reg_wr(`SMTE_ADDR_MODE, {16'h0002, 8'h01, rows[r][19:16], 4'h0});
      pulses = 0;
      reg_wr(`SMTE_ADDR_TX, {24'h0, rows[r][15:8]});
      wait_done();
      chk("clock pulses", 32'h8, pulses);
      chk("select", 32'h1 << rows[r][19:16], {28'h0, ~seen_cs});
      chk("slave word", rows[r][15:8], got);
      reg_rd(`SMTE_ADDR_RX);
      chk("rx word", rows[r][7:0], d);
      reg_rd(`SMTE_ADDR_STATUS);
      chk("status", 32'h13, d);
    end
    // second word queued, first never read
    reg_wr(`SMTE_ADDR_MODE, 32'h0000_0100);
    reply = 8'h5a;
    pulses = 0;
    reg_wr(`SMTE_ADDR_TX, 32'h11);
    reg_wr(`SMTE_ADDR_TX, 32'h22);
    reg_rd(`SMTE_ADDR_STATUS);
    chk("tx empty", 32'h0, d & 32'h1);
    chk("dma", 32'h0, dma);
    reply = 8'ha6;
    wait_done();
    chk("slave word", 32'h22, got);
    chk("clock pulses", 32'h10, pulses);
    reg_rd(`SMTE_ADDR_STATUS);
    chk("status", 32'h1f, d);
    reg_rd(`SMTE_ADDR_RX);
    chk("rx word", 32'ha6, d);
    reg_rd(`SMTE_ADDR_STATUS);
    chk("status", 32'h13, d);
    chk("dma", 32'h1, dma);
    // wait for the rx read before the next word
    reg_wr(`SMTE_ADDR_MODE, 32'h0000_0101);
    reply = 8'h3c;
    reg_wr(`SMTE_ADDR_TX, 32'h44);
    wait_done();
    reg_wr(`SMTE_ADDR_TX, 32'h55);
    repeat (40) @(posedge clk);
    reg_rd(`SMTE_ADDR_STATUS);
    chk("held", 32'h0, d & 32'h21);
    reg_rd(`SMTE_ADDR_RX);
    chk("rx word", 32'h3c, d);
    wait_done();
    chk("slave word", 32'h55, got);
    // long delay after the last word
    reg_wr(`SMTE_ADDR_MODE, 32'h0040_0100);
    reg_wr(`SMTE_ADDR_TX, 32'h66);
    repeat (50) @(posedge clk);
    reg_rd(`SMTE_ADDR_STATUS);
    chk("done early", 32'h0, d & 32'h2);
    wait_done();
    reg_rd(`SMTE_ADDR_STATUS);
    chk("done", 32'h2, d & 32'h2);
    // done interrupt raised and cleared
    reg_wr(`SMTE_ADDR_IPEND, 32'hf);
    reg_wr(`SMTE_ADDR_IMASK, 32'h2);
    reg_rd(`SMTE_ADDR_IPEND);
    chk("irq", 32'h0, irq);
    reg_wr(`SMTE_ADDR_MODE, 32'h0000_0100);
    reg_wr(`SMTE_ADDR_TX, 32'h77);
    wait_done();
    chk("irq", 32'h1, irq);
    reg_wr(`SMTE_ADDR_IPEND, 32'h2);
    reg_rd(`SMTE_ADDR_IPEND);
    chk("irq", 32'h0, irq);
    reg_wr(4'hf, 32'hffff_ffff);
    reg_rd(4'hf);
    chk("unmapped", 32'h0, d);
    // reset again: flags off until enabled
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    reg_rd(`SMTE_ADDR_STATUS);
    chk("status off", 32'h0, d);
    reg_wr(`SMTE_ADDR_TX, 32'h33);
    reg_rd(`SMTE_ADDR_STATUS);
    chk("tx ignored", 32'h0, d);
    reg_wr(`SMTE_ADDR_CTRL, 32'h1);
    reg_rd(`SMTE_ADDR_STATUS);
    chk("status on", 32'h13, d);
    results();
  end
endmodule
